// [src/pmi_cfg.svh]
// Register offsets, field positions, reset values and decode limits
`ifndef PMI_CFG_SVH
`define PMI_CFG_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define PMI_OFS_INPUT     8'h00
`define PMI_OFS_OUTPUT    8'h04
`define PMI_OFS_DIRECTION 8'h08
`define PMI_OFS_FLAG      8'h0c
`define PMI_OFS_EDGE      8'h10
`define PMI_OFS_ENABLE    8'h14
`define PMI_OFS_SELECT    8'h18
`define PMI_OFS_CTRL      8'h1c

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define PMI_LCD_FIELD_LSB 0
`define PMI_LCD_FIELD_MSB 3
`define PMI_SUP_LEVEL_LSB 4
`define PMI_SUP_LEVEL_MSB 7

// ----------------------------------------------------------------
// Reset values and decode limits
// ----------------------------------------------------------------
`define PMI_RST_BYTE       8'h00
`define PMI_LCD_PORT_LIMIT 4'h4
`define PMI_SUP_EXT_CODE   4'hf
`define PMI_PAD_MASK       8'h3f
`define PMI_PAD_PINS       6

`endif

// [src/pmi_pkg.sv]
// Types shared by the port, its flag logic and their interface
package pmi_pkg;

	typedef logic [7:0] pmi_byte_t;

	typedef enum logic [1:0] {
		PMI_MODE_PORT   = 2'b00,
		PMI_MODE_MODULE = 2'b01,
		PMI_MODE_LCD    = 2'b10,
		PMI_MODE_OFF    = 2'b11
	} pmi_pin_mode_e;

endpackage

// [src/pmi_flag_if.sv]
// Carrier between the port top and its edge flag logic
interface pmi_flag_if
	import pmi_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn
);
	pmi_byte_t level;
	pmi_byte_t edge_sel;
	pmi_byte_t wr_data;
	logic      wr_en;
	pmi_byte_t flag;

	modport ctrl  (output level, edge_sel, wr_data, wr_en, input flag);
	modport flags (input pclk, presetn, level, edge_sel, wr_data, wr_en,
		output flag);
endinterface

// [src/pmi_sync.sv]
// Two flip-flop synchroniser for pad inputs
module pmi_sync
	import pmi_pkg::*;
#(
	parameter int W = 6
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] stage1;

	// Stage one feeds only stage two
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1 <= '0;
			q      <= '0;
		end else begin
			stage1 <= d;
			q      <= stage1;
		end
	end
endmodule

// [src/pmi_edge_flags.sv]
// Edge detection for the six pad bits and sticky interrupt flags for all eight bits
`include "pmi_cfg.svh"
module pmi_edge_flags
	import pmi_pkg::*;
(
	pmi_flag_if.flags fi
);
	pmi_byte_t prev;
	logic      primed;
	pmi_byte_t rise;
	pmi_byte_t fall;
	pmi_byte_t hit;

	// ----------------------------------------------------------------
	// Edge selection
	// ----------------------------------------------------------------
	assign rise = fi.level & ~prev;
	assign fall = ~fi.level & prev;
	// Bits without pads never see an edge; software alone moves them
	assign hit  = primed ? (((rise & ~fi.edge_sel) | (fall & fi.edge_sel))
		& `PMI_PAD_MASK) : `PMI_RST_BYTE;

	// ----------------------------------------------------------------
	// Flags
	// ----------------------------------------------------------------
	// First cycle after reset only loads prev, but pad_sync also resets low,
	// so a pin already high at release still fakes a rising edge once it passes the synchroniser
	always_ff @(posedge fi.pclk or negedge fi.presetn) begin
		if (!fi.presetn) begin
			prev   <= `PMI_RST_BYTE;
			primed <= 1'b0;
		end else begin
			prev   <= fi.level;
			primed <= 1'b1;
		end
	end

	// An edge in the clearing cycle still sets its flag
	always_ff @(posedge fi.pclk or negedge fi.presetn) begin
		if (!fi.presetn)
			fi.flag <= `PMI_RST_BYTE;
		else if (fi.wr_en)
			fi.flag <= fi.wr_data | hit;
		else
			fi.flag <= fi.flag | hit;
	end
endmodule

// [src/pmi_port.sv]
// Eight-bit port with pin function mux, LCD share and edge interrupts
//
// Function
// - Pins 0 and 1 are port pins only while port/LCD select is 0.
// - LCD select is 1 when LCD field >= 04h; pin0 segment b, pin1 a.
// - Pin0 select: timer ch2 output out, input to capture A, own dir.
// - Pin1 select: serial unit drives direction and clock, gets clock.
// - Pin 3 port and input path active only without disable.
// - Pin3 input disabled when supervisor level is 1111b; pins 0 and 1 while in LCD mode.
// - Pin2 select: forced input, feeds slave transmit enable, out low.
// - Pin3 select: drives low, direction from its bit, input unused.
// - Pin4 select: forced output carrying async transmit data.
// - Pin5 select: forced input feeding async receive data, out low.
// - Flag set on selected edge; request when flag and enable set.
// - Bits 6 and 7 have full registers, no pins, software flags.
`include "pmi_cfg.svh"
module pmi_port
	import pmi_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [5:0]  pad_in,
	output logic      [5:0]  pad_out,
	output logic      [5:0]  pad_oe_n,
	input  wire logic        timer_ch2_output,
	output logic             capture_input_ch2_a,
	input  wire logic        serial_clock_from_unit,
	input  wire logic        serial_clock_dir_ctrl,
	output logic             serial_clock_to_unit,
	output logic             slave_transmit_enable,
	input  wire logic        async_transmit_data,
	output logic             async_receive_data,
	input  wire logic        lcd_segment_a,
	input  wire logic        lcd_segment_b,
	output logic             supervisor_ext_input,
	output logic             port_irq_request
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	pmi_byte_t     pin_function_select;
	pmi_byte_t     pin_direction;
	pmi_byte_t     pin_output_value;
	pmi_byte_t     pin_irq_enable;
	pmi_byte_t     pin_edge_select;
	pmi_byte_t     lcd_control_byte;
	pmi_byte_t     pin_input_value;
	logic [3:0]    lcd_port_control_field;
	logic [3:0]    supervisor_level_select;
	logic [5:0]    pad_sync;
	logic          lcd_mode;
	logic          input_buffer_disable;
	pmi_pin_mode_e mode [0:5];
	logic [5:0]    in_on;
	logic [5:0]    drive_en;
	logic [5:0]    drive_val;
	logic [5:0]    next_pad_out;
	logic [5:0]    next_pad_oe_n;
	logic [7:0]    word_addr;
	logic          setup_phase;
	logic          access_phase;
	logic          hit_input;
	logic          hit_output;
	logic          hit_dir;
	logic          hit_flag;
	logic          hit_edge;
	logic          hit_enable;
	logic          hit_select;
	logic          hit_ctrl;
	logic          mapped;
	logic          wr_ok;
	pmi_byte_t     rd_byte;
	logic [31:0]   next_prdata;

	pmi_flag_if flag_bus (
		.pclk    (pclk),
		.presetn (presetn)
	);

	// ----------------------------------------------------------------
	// Pin mode decode
	// ----------------------------------------------------------------
	// Disable outranks LCD, which outranks the module function
	function automatic pmi_pin_mode_e pin_mode(
		input logic sel,
		input logic lcd,
		input logic off
	);
		if (off)
			return PMI_MODE_OFF;
		else if (lcd)
			return PMI_MODE_LCD;
		else if (sel)
			return PMI_MODE_MODULE;
		else
			return PMI_MODE_PORT;
	endfunction

	assign lcd_port_control_field  = lcd_control_byte[`PMI_LCD_FIELD_MSB:
		`PMI_LCD_FIELD_LSB];
	assign supervisor_level_select = lcd_control_byte[`PMI_SUP_LEVEL_MSB:
		`PMI_SUP_LEVEL_LSB];
	assign lcd_mode = (lcd_port_control_field >= `PMI_LCD_PORT_LIMIT);
	assign input_buffer_disable =
		(supervisor_level_select == `PMI_SUP_EXT_CODE);

	assign mode[0] = pin_mode(pin_function_select[0], lcd_mode, 1'b0);
	assign mode[1] = pin_mode(pin_function_select[1], lcd_mode, 1'b0);
	// Pins 2, 4 and 5 never have their input buffer disabled
	assign mode[2] = pin_mode(pin_function_select[2], 1'b0, 1'b0);
	assign mode[3] = pin_mode(pin_function_select[3], 1'b0,
		input_buffer_disable);
	assign mode[4] = pin_mode(pin_function_select[4], 1'b0, 1'b0);
	assign mode[5] = pin_mode(pin_function_select[5], 1'b0, 1'b0);

	// ----------------------------------------------------------------
	// Pin output and direction selection
	// ----------------------------------------------------------------
	assign drive_en[0]  = (mode[0] == PMI_MODE_LCD) ? 1'b1
		: pin_direction[0];
	assign drive_val[0] = (mode[0] == PMI_MODE_LCD) ? lcd_segment_b
		: (mode[0] == PMI_MODE_MODULE) ? timer_ch2_output
		: pin_output_value[0];

	assign drive_en[1]  = (mode[1] == PMI_MODE_LCD) ? 1'b1
		: (mode[1] == PMI_MODE_MODULE) ? serial_clock_dir_ctrl
		: pin_direction[1];
	assign drive_val[1] = (mode[1] == PMI_MODE_LCD) ? lcd_segment_a
		: (mode[1] == PMI_MODE_MODULE) ? serial_clock_from_unit
		: pin_output_value[1];

	assign drive_en[2]  = (mode[2] == PMI_MODE_MODULE) ? 1'b0
		: pin_direction[2];
	assign drive_val[2] = (mode[2] == PMI_MODE_MODULE) ? 1'b0
		: pin_output_value[2];

	// A disabled pin 3 is handed to the supervisor, so it is never driven
	assign drive_en[3]  = (mode[3] == PMI_MODE_OFF) ? 1'b0
		: pin_direction[3];
	assign drive_val[3] = (mode[3] == PMI_MODE_PORT) ? pin_output_value[3]
		: 1'b0;

	assign drive_en[4]  = (mode[4] == PMI_MODE_MODULE) ? 1'b1
		: pin_direction[4];
	assign drive_val[4] = (mode[4] == PMI_MODE_MODULE) ? async_transmit_data
		: pin_output_value[4];

	assign drive_en[5]  = (mode[5] == PMI_MODE_MODULE) ? 1'b0
		: pin_direction[5];
	assign drive_val[5] = (mode[5] == PMI_MODE_MODULE) ? 1'b0
		: pin_output_value[5];

	assign next_pad_out  = drive_val & drive_en;
	assign next_pad_oe_n = ~drive_en;

	// Registered pads cost one cycle of latency on module signals too
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_out  <= '0;
			pad_oe_n <= '1;
		end else begin
			pad_out  <= next_pad_out;
			pad_oe_n <= next_pad_oe_n;
		end
	end

	// ----------------------------------------------------------------
	// Pin input path
	// ----------------------------------------------------------------
	pmi_sync #(
		.W (`PMI_PAD_PINS)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (pad_in),
		.q       (pad_sync)
	);

	assign in_on[0] = (mode[0] != PMI_MODE_LCD);
	assign in_on[1] = (mode[1] != PMI_MODE_LCD);
	assign in_on[2] = 1'b1;
	assign in_on[3] = (mode[3] != PMI_MODE_OFF);
	assign in_on[4] = 1'b1;
	assign in_on[5] = 1'b1;

	// Pins without pads read as zero
	assign pin_input_value = {2'b00, pad_sync & in_on};

	assign capture_input_ch2_a   = (mode[0] == PMI_MODE_MODULE)
		& pad_sync[0];
	assign serial_clock_to_unit  = (mode[1] == PMI_MODE_MODULE)
		& pad_sync[1];
	assign slave_transmit_enable = (mode[2] == PMI_MODE_MODULE)
		& pad_sync[2];
	assign async_receive_data    = (mode[5] == PMI_MODE_MODULE)
		& pad_sync[5];
	assign supervisor_ext_input  = input_buffer_disable;

	// ----------------------------------------------------------------
	// Interrupt flags
	// ----------------------------------------------------------------
	assign flag_bus.level    = pin_input_value;
	assign flag_bus.edge_sel = pin_edge_select;
	assign flag_bus.wr_data  = pwdata[7:0];
	assign flag_bus.wr_en    = wr_ok & hit_flag;

	pmi_edge_flags u_flags (
		.fi (flag_bus)
	);

	assign port_irq_request = |(flag_bus.flag & pin_irq_enable);

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	assign word_addr    = {paddr[7:2], 2'b00};
	assign setup_phase  = psel & ~penable;
	assign access_phase = psel & penable;
	assign hit_input    = (word_addr == `PMI_OFS_INPUT);
	assign hit_output   = (word_addr == `PMI_OFS_OUTPUT);
	assign hit_dir      = (word_addr == `PMI_OFS_DIRECTION);
	assign hit_flag     = (word_addr == `PMI_OFS_FLAG);
	assign hit_edge     = (word_addr == `PMI_OFS_EDGE);
	assign hit_enable   = (word_addr == `PMI_OFS_ENABLE);
	assign hit_select   = (word_addr == `PMI_OFS_SELECT);
	assign hit_ctrl     = (word_addr == `PMI_OFS_CTRL);
	assign mapped       = hit_input | hit_output | hit_dir | hit_flag
		| hit_edge | hit_enable | hit_select | hit_ctrl;
	// Only lane 0 holds data; writes with lane 0 off change nothing
	assign wr_ok        = access_phase & pwrite & mapped & pstrb[0];

	// Zero wait states; unmapped addresses answer with an error
	assign pready  = 1'b1;
	assign pslverr = access_phase & ~mapped;

	assign rd_byte = hit_input  ? pin_input_value
		: hit_output ? pin_output_value
		: hit_dir    ? pin_direction
		: hit_flag   ? flag_bus.flag
		: hit_edge   ? pin_edge_select
		: hit_enable ? pin_irq_enable
		: hit_select ? pin_function_select
		: hit_ctrl   ? lcd_control_byte
		: `PMI_RST_BYTE;
	assign next_prdata = {24'h000000, rd_byte};

	// Read data is captured in the setup cycle and held through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= '0;
		else if (setup_phase && !pwrite)
			prdata <= next_prdata;
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_function_select <= `PMI_RST_BYTE;
			pin_direction       <= `PMI_RST_BYTE;
			pin_output_value    <= `PMI_RST_BYTE;
			pin_irq_enable      <= `PMI_RST_BYTE;
			pin_edge_select     <= `PMI_RST_BYTE;
			lcd_control_byte    <= `PMI_RST_BYTE;
		end else if (wr_ok) begin
			if (hit_select)
				pin_function_select <= pwdata[7:0];
			if (hit_dir)
				pin_direction <= pwdata[7:0];
			if (hit_output)
				pin_output_value <= pwdata[7:0];
			if (hit_enable)
				pin_irq_enable <= pwdata[7:0];
			if (hit_edge)
				pin_edge_select <= pwdata[7:0];
			if (hit_ctrl)
				lcd_control_byte <= pwdata[7:0];
		end
	end

endmodule

// [sim/pmi_port_chk.sv]
// Concurrent checks on the port's pins, module lines and interrupt
module pmi_port_chk
	import pmi_pkg::*;
(
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pwrite,
	input wire logic [5:0] pad_in,
	input wire logic [5:0] pad_out,
	input wire logic [5:0] pad_oe_n,
	input wire logic       capture_input_ch2_a,
	input wire logic       serial_clock_from_unit,
	input wire logic       serial_clock_dir_ctrl,
	input wire logic       serial_clock_to_unit,
	input wire logic       slave_transmit_enable,
	input wire logic       async_receive_data,
	input wire logic       supervisor_ext_input,
	input wire logic       port_irq_request
);
	// --------
	// Properties
	// --------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Module inputs carry the pad level two edges late
	chk_cap_in_sync: assert property (
		capture_input_ch2_a |-> $past(pad_in[0], 2))
		else $error("capture input high without pad0 high");
	chk_sck_in_sync: assert property (
		serial_clock_to_unit |-> $past(pad_in[1], 2))
		else $error("serial clock in high without pad1 high");
	chk_ste_in_sync: assert property (
		slave_transmit_enable |-> $past(pad_in[2], 2))
		else $error("transmit enable high without pad2 high");
	chk_rxd_in_sync: assert property (
		async_receive_data |-> $past(pad_in[5], 2))
		else $error("receive data high without pad5 high");
	chk_ste_forced_in: assert property (
		slave_transmit_enable && $past(slave_transmit_enable)
		|-> pad_oe_n[2] && !pad_out[2])
		else $error("pad2 driven in module mode");
	chk_rxd_forced_in: assert property (
		async_receive_data && $past(async_receive_data)
		|-> pad_oe_n[5] && !pad_out[5])
		else $error("pad5 driven in module mode");
	chk_sup_pin_off: assert property (
		supervisor_ext_input && $past(supervisor_ext_input) |-> pad_oe_n[3])
		else $error("pad3 driven while routed to supervisor");
	chk_sck_drive: assert property (
		serial_clock_to_unit && $past(serial_clock_to_unit)
		&& $past(serial_clock_dir_ctrl) |-> !pad_oe_n[1]
		&& pad_out[1] == $past(serial_clock_from_unit))
		else $error("pad1 not driven by serial clock");
	// Only a register write may drop the request
	chk_irq_sticky: assert property (
		$fell(port_irq_request) |-> $past(psel && penable && pwrite))
		else $error("interrupt request fell without a write");
endmodule

bind pmi_port pmi_port_chk i_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pad_in(pad_in),
	.pad_out(pad_out), .pad_oe_n(pad_oe_n),
	.capture_input_ch2_a(capture_input_ch2_a),
	.serial_clock_from_unit(serial_clock_from_unit),
	.serial_clock_dir_ctrl(serial_clock_dir_ctrl),
	.serial_clock_to_unit(serial_clock_to_unit),
	.slave_transmit_enable(slave_transmit_enable),
	.async_receive_data(async_receive_data),
	.supervisor_ext_input(supervisor_ext_input),
	.port_irq_request(port_irq_request));

// [sim/pmi_pins_model.sv]
// Board side of the six pads: device drive or outside driver
module pmi_pins_model
	import pmi_pkg::*;
(
	input  wire logic [5:0] pad_out,
	input  wire logic [5:0] pad_oe_n,
	input  wire logic [5:0] ext,
	output logic      [5:0] pad_in
);
	// --------
	// Pad level
	// --------
	// A driven pad loops back, so module inputs see our own output
	assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext);
endmodule

// [sim/tb_top.sv]
// Bench for the eight-bit port: bus tasks and pin scenarios
`include "pmi_cfg.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
	mismatches++; $display("Error %s expected %h seen %h", n, e, g); end end
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        pclk = 1'b0, presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic [3:0]  pstrb = 4'hf;
	logic        pready, pslverr, rerr;
	logic [5:0]  pad_in, pad_out, pad_oe_n, ext = 6'h00;
	logic        tmr = 1'b0, sck_o = 1'b0, sck_d = 1'b0, txd = 1'b0;
	logic        seg_a = 1'b0, seg_b = 1'b0;
	logic        cap, sck_i, ste, rxd, sup, irq;
	logic [7:0]  lcdv [3] = '{8'h03, 8'h04, 8'h0f};
	int          mismatches = 0;
	int          checked = 0;
	// --------
	// Clock, reset, parts
	// --------
	always #12.5 pclk = ~pclk;
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
	end
	pmi_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
		.timer_ch2_output(tmr), .capture_input_ch2_a(cap),
		.serial_clock_from_unit(sck_o), .serial_clock_dir_ctrl(sck_d),
		.serial_clock_to_unit(sck_i), .slave_transmit_enable(ste),
		.async_transmit_data(txd), .async_receive_data(rxd),
		.lcd_segment_a(seg_a), .lcd_segment_b(seg_b),
		.supervisor_ext_input(sup), .port_irq_request(irq));
	pmi_pins_model i_pins (.pad_out(pad_out), .pad_oe_n(pad_oe_n),
		.ext(ext), .pad_in(pad_in));
	// --------
	// Tasks
	// --------
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [7:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		// No wait-state count assumed; only the watchdog ends a hang
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(a, 1'b1, d, 4'hf);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		apb(a, 1'b0, 8'h00, 4'hf);
		`CHK("prdata", {24'h0, e}, rdat)
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	task automatic pads(input logic [5:0] v);
		@(posedge pclk);
		ext <= v;
	endtask
	task automatic print_verdict();
		if (mismatches == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Far above the fewer than two hundred cycles the tests take
	initial begin
		#200000;
		mismatches++;
		print_verdict();
	end
	// --------
	// Tests
	// --------
	initial begin
		wait (presetn === 1'b1);
		idle(1);
		`CHK("pad_oe_n", 6'h3f, pad_oe_n)
		`CHK("pready", 1'b1, pready)
		for (int a = 0; a < 8; a++) rd(8'(a * 4), 8'h00);
		apb(8'h20, 1'b0, 8'h00, 4'hf);
		`CHK("pslverr", 1'b1, rerr)
		apb(`PMI_OFS_OUTPUT, 1'b1, 8'hff, 4'h0);
		rd(`PMI_OFS_OUTPUT, 8'h00);
		wr(`PMI_OFS_DIRECTION, 8'hff);
		wr(`PMI_OFS_OUTPUT, 8'hea);
		idle(2);
		`CHK("pad_oe_n", 6'h00, pad_oe_n)
		`CHK("pad_out", 6'h2a, pad_out)
		rd(`PMI_OFS_OUTPUT, 8'hea);
		wr(`PMI_OFS_DIRECTION, 8'hc0);
		pads(6'h15);
		idle(3);
		rd(`PMI_OFS_INPUT, 8'h15);
		wr(`PMI_OFS_EDGE, 8'h02);
		wr(`PMI_OFS_FLAG, 8'h00);
		wr(`PMI_OFS_ENABLE, 8'hff);
		`CHK("irq", 1'b0, irq)
		pads(6'h16);
		idle(4);
		rd(`PMI_OFS_FLAG, 8'h00);
		pads(6'h15);
		idle(4);
		rd(`PMI_OFS_FLAG, 8'h03);
		`CHK("irq", 1'b1, irq)
		wr(`PMI_OFS_ENABLE, 8'hfc);
		idle(1);
		`CHK("irq", 1'b0, irq)
		wr(`PMI_OFS_FLAG, 8'h80);
		idle(1);
		`CHK("irq", 1'b1, irq)
		rd(`PMI_OFS_FLAG, 8'h80);
		wr(`PMI_OFS_FLAG, 8'h00);
		idle(1);
		`CHK("irq", 1'b0, irq)
		@(posedge pclk);
		{tmr, sck_o, sck_d, txd, seg_a} <= 5'h1f;
		pads(6'h24);
		wr(`PMI_OFS_DIRECTION, 8'h3f);
		wr(`PMI_OFS_OUTPUT, 8'h00);
		wr(`PMI_OFS_SELECT, 8'h3f);
		idle(4);
		`CHK("pad_oe_n", 6'h24, pad_oe_n)
		`CHK("pad_out", 6'h13, pad_out)
		`CHK("mod_in", 4'hf, {cap, sck_i, ste, rxd})
		@(posedge pclk);
		sck_d <= 1'b0;
		wr(`PMI_OFS_DIRECTION, 8'h26);
		idle(4);
		`CHK("pad_oe_n", 6'h2f, pad_oe_n)
		`CHK("pad_out", 6'h10, pad_out)
		foreach (lcdv[i]) begin
			wr(`PMI_OFS_CTRL, lcdv[i]);
			idle(2);
			`CHK("lcd_oe", (i > 0) ? 2'b00 : 2'b11, pad_oe_n[1:0])
			`CHK("lcd_out", (i > 0) ? 2'b10 : 2'b00, pad_out[1:0])
		end
		wr(`PMI_OFS_DIRECTION, 8'h2e);
		// Pad 3 held high outside, so a live input path would read it
		pads(6'h2c);
		for (int k = 0; k < 2; k++) begin
			wr(`PMI_OFS_CTRL, (k == 0) ? 8'hf0 : 8'he0);
			idle(2);
			rd(`PMI_OFS_INPUT, 8'h34);
			`CHK("sup", (k == 0), sup)
			`CHK("pad3_oe", (k == 0), pad_oe_n[3])
		end
		print_verdict();
	end
endmodule
